// ===== fljvf_defs.svh
// Purpose: Constants of the frequency limit, jump and V/F block.
// Assumes: Frequencies in 0.1 Hz, voltages in 1 V, boost in 0.1 %.
// Notes:   Codes 8888 and 9999 lie above every real setting.
`ifndef FLJVF_DEFS_SVH
`define FLJVF_DEFS_SVH
`define FLJ_OFF       16'h270F
`define FLJ_V95       16'h22B8
`define FLJ_SEL_SET2  5'h03
`define FLJ_ID_BOOST  8'h00
`define FLJ_ID_MAXF   8'h01
`define FLJ_ID_MINF   8'h02
`define FLJ_ID_BASEF  8'h03
`define FLJ_ID_STARTF 8'h0D
`define FLJ_ID_PATT   8'h0E
`define FLJ_ID_JOGF   8'h0F
`define FLJ_ID_BASEV  8'h13
`define FLJ_ID_CURVE  8'h1D
`define FLJ_ID_JUMP0  8'h1F
`define FLJ_ID_BOOST2 8'h2E
`define FLJ_ID_SBASEF 8'h2F
`define FLJ_ID_RATEDV 8'h53
`define FLJ_ID_RATEDF 8'h54
`define FLJ_ID_GROUP  8'hA0
`define FLJ_RST_MAXF  16'h04B0
`define FLJ_RST_BASEF 16'h01F4
`define FLJ_RST_STRTF 16'h0005
`define FLJ_RST_JOGF  16'h0032
`define FLJ_RST_BOOST 16'h0032
`define FLJ_RST_RATV  16'h00C8
`define FLJ_RST_RATF  16'h01F4
`define FLJ_CURVE_SA  16'h0001
`define FLJ_STEP      16'h0001
`define FLJ_TICK_NS   1000
`define FLJ_CLK_NS    10
`define FLJ_TICK_CYC  (`FLJ_TICK_NS / `FLJ_CLK_NS)
`endif

// ===== fljvf_pkg.sv
// Purpose: Types of the frequency limit, jump and V/F block.
// Assumes: Nothing beyond the constants header.
// Notes:   Pattern codes follow the load pattern setting.
package fljvf_pkg;
  typedef logic [15:0] fljvf_val_t;
  typedef enum logic [1:0] {
    FLJVF_LINEAR,
    FLJVF_SQUARE,
    FLJVF_HOIST_FWD,
    FLJVF_HOIST_REV
  } fljvf_patt_t;
endpackage

// ===== fljvf_top.sv
// Purpose: Frequency clamp, jump zones, ramp and V/F characteristic.
// Assumes: All inputs synchronous to CORE_CLK_IN.
// Notes:   Settings load through a write port, locked by user group.
`timescale 1ns/1ps
`include "fljvf_defs.svh"
module fljvf_top (
  // Clock and reset.
  input  wire logic                CORE_CLK_IN,
  input  wire logic                RST_IN,
  // Setting write port.
  input  wire logic                PARAM_WR_IN,
  input  wire logic [7:0]          PARAM_ID_IN,
  input  wire fljvf_pkg::fljvf_val_t PARAM_DATA_IN,
  // Run control and command.
  input  wire logic                START_IN,
  input  wire logic                REVERSE_IN,
  input  wire logic                JOG_IN,
  input  wire fljvf_pkg::fljvf_val_t FREQ_CMD_IN,
  input  wire logic                STALL_IN,
  input  wire fljvf_pkg::fljvf_val_t STALL_FREQ_IN,
  input  wire logic                FLUX_MODE_IN,
  input  wire fljvf_pkg::fljvf_val_t SUPPLY_VOLT_IN,
  // Input terminals and their function codes.
  input  wire logic [6:0]          TERM_IN,
  input  wire logic [34:0]         TERM_FUNC_IN,
  // Drive outputs.
  output logic                     WR_REJECT_OUT,
  output logic                     SECOND_SET_OUT,
  output fljvf_pkg::fljvf_val_t    TARGET_OUT,
  output fljvf_pkg::fljvf_val_t    FREQ_OUT,
  output fljvf_pkg::fljvf_val_t    VOLT_OUT,
  output fljvf_pkg::fljvf_val_t    BOOST_OUT,
  output fljvf_pkg::fljvf_val_t    BASE_FREQ_OUT,
  output fljvf_pkg::fljvf_val_t    INFLECT_OUT
);
  import fljvf_pkg::*;

  fljvf_val_t  maxf_ff, minf_ff, basef_ff, startf_ff, jogf_ff;
  fljvf_val_t  basev_ff, curve_ff, sbasef_ff, ratv_ff, ratf_ff;
  fljvf_val_t  boost_ff, boost2_ff, group_ff;
  fljvf_patt_t patt_ff;
  fljvf_val_t  jump_ff [6];
  logic [6:0]  sel_hit;
  logic [2:0]  zone_hit;
  fljvf_val_t  zone_val [3];
  logic        second_set_ff;
  fljvf_val_t  nxt_target, raw_cmd, target_ff, freq_ff;
  fljvf_val_t  vbase, fbase, volt_ff, boost_out_ff;
  fljvf_val_t  fbase_ff, inflect_ff;
  logic [6:0]  tick_ff;
  logic        reject_ff, wr_ok;
  logic [47:0] num;
  logic [31:0] den;
  fljvf_val_t  nxt_volt;

  assign wr_ok = PARAM_WR_IN &&
                 (group_ff == 16'h0000 || PARAM_ID_IN == `FLJ_ID_GROUP);

  // Setting store; a locked write is dropped and flagged.
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      maxf_ff   <= `FLJ_RST_MAXF;
      minf_ff   <= 16'h0000;
      basef_ff  <= `FLJ_RST_BASEF;
      startf_ff <= `FLJ_RST_STRTF;
      jogf_ff   <= `FLJ_RST_JOGF;
      basev_ff  <= `FLJ_V95;
      curve_ff  <= 16'h0000;
      sbasef_ff <= `FLJ_OFF;
      ratv_ff   <= `FLJ_RST_RATV;
      ratf_ff   <= `FLJ_RST_RATF;
      boost_ff  <= `FLJ_RST_BOOST;
      boost2_ff <= `FLJ_OFF;
      group_ff  <= 16'h0000;
      patt_ff   <= FLJVF_LINEAR;
    end else if (wr_ok) begin
      case (PARAM_ID_IN)
        `FLJ_ID_MAXF:   maxf_ff   <= PARAM_DATA_IN;
        `FLJ_ID_MINF:   minf_ff   <= PARAM_DATA_IN;
        `FLJ_ID_BASEF:  basef_ff  <= PARAM_DATA_IN;
        `FLJ_ID_STARTF: startf_ff <= PARAM_DATA_IN;
        `FLJ_ID_JOGF:   jogf_ff   <= PARAM_DATA_IN;
        `FLJ_ID_BASEV:  basev_ff  <= PARAM_DATA_IN;
        `FLJ_ID_CURVE:  curve_ff  <= PARAM_DATA_IN;
        `FLJ_ID_SBASEF: sbasef_ff <= PARAM_DATA_IN;
        `FLJ_ID_RATEDV: ratv_ff   <= PARAM_DATA_IN;
        `FLJ_ID_RATEDF: ratf_ff   <= PARAM_DATA_IN;
        `FLJ_ID_BOOST:  boost_ff  <= PARAM_DATA_IN;
        `FLJ_ID_BOOST2: boost2_ff <= PARAM_DATA_IN;
        `FLJ_ID_GROUP:  group_ff  <= PARAM_DATA_IN;
        `FLJ_ID_PATT:   patt_ff   <= fljvf_patt_t'(PARAM_DATA_IN[1:0]);
        default: ;
      endcase
    end
  end

  // Jump settings, one entry per boundary.
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_jump
      always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
          jump_ff[gi] <= `FLJ_OFF;
        end else if (wr_ok && PARAM_ID_IN == `FLJ_ID_JUMP0 + 8'(gi)) begin
          jump_ff[gi] <= PARAM_DATA_IN;
        end
      end
    end
    for (gi = 0; gi < 7; gi++) begin : g_term
      assign sel_hit[gi] = TERM_IN[gi] &&
                           TERM_FUNC_IN[gi*5 +: 5] == `FLJ_SEL_SET2;
    end
    for (gi = 0; gi < 3; gi++) begin : g_zone
      fljvf_val_t za, zb;
      assign za = jump_ff[2*gi];
      assign zb = jump_ff[2*gi+1];
      assign zone_val[gi] = za;
      assign zone_hit[gi] = za != `FLJ_OFF && zb != `FLJ_OFF &&
        raw_cmd >= (za < zb ? za : zb) &&
        raw_cmd <= (za < zb ? zb : za);
    end
  endgenerate

  // Steady command: jog, minimum and maximum clamps.
  always_comb begin
    raw_cmd = FREQ_CMD_IN;
    if (!START_IN && !JOG_IN) begin
      raw_cmd = 16'h0000;
    end else if (JOG_IN) begin
      raw_cmd = jogf_ff;
    end else if (FREQ_CMD_IN < minf_ff) begin
      raw_cmd = (minf_ff >= startf_ff) ? minf_ff : 16'h0000;
    end
    if (raw_cmd > maxf_ff) begin
      raw_cmd = maxf_ff;
    end
  end

  always_comb begin
    nxt_target = raw_cmd;
    if (zone_hit[0]) begin
      nxt_target = zone_val[0];
    end else if (zone_hit[1]) begin
      nxt_target = zone_val[1];
    end else if (zone_hit[2]) begin
      nxt_target = zone_val[2];
    end
  end

  // Target and second set registers.
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      target_ff     <= 16'h0000;
      second_set_ff <= 1'b0;
    end else begin
      target_ff     <= nxt_target;
      second_set_ff <= |sel_hit;
    end
  end

  // Ramp tick counter.
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      tick_ff <= 7'h00;
    end else if (tick_ff == 7'(`FLJ_TICK_CYC - 1)) begin
      tick_ff <= 7'h00;
    end else begin
      tick_ff <= tick_ff + 7'h01;
    end
  end

  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      freq_ff <= 16'h0000;
    end else if (STALL_IN && STALL_FREQ_IN < freq_ff) begin
      freq_ff <= STALL_FREQ_IN;
    end else if (tick_ff == 7'h00 && freq_ff < target_ff) begin
      freq_ff <= freq_ff + `FLJ_STEP;
    end else if (tick_ff == 7'h00 && freq_ff > target_ff) begin
      freq_ff <= freq_ff - `FLJ_STEP;
    end
  end

  // Base point selection.
  always_comb begin
    if (basev_ff == `FLJ_OFF) begin
      vbase = SUPPLY_VOLT_IN;
    end else if (basev_ff == `FLJ_V95) begin
      vbase = 16'((32'(SUPPLY_VOLT_IN) * 32'h5F) / 32'h64);
    end else begin
      vbase = (basev_ff < SUPPLY_VOLT_IN) ? basev_ff : SUPPLY_VOLT_IN;
    end
    fbase = (second_set_ff && sbasef_ff != `FLJ_OFF) ? sbasef_ff
                                                     : basef_ff;
    if (FLUX_MODE_IN) begin
      vbase = ratv_ff;
      fbase = ratf_ff;
    end
  end

  always_comb begin
    num = 48'(vbase) * 48'(freq_ff);
    den = 32'(fbase);
    if (patt_ff == FLJVF_SQUARE && !FLUX_MODE_IN) begin
      num = num * 48'(freq_ff);
      den = den * 32'(fbase);
    end
    if (freq_ff >= fbase || den == 32'h0) begin
      nxt_volt = vbase;
    end else begin
      nxt_volt = 16'(num / 48'(den));
    end
  end

  // Voltage, base point and boost registers.
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      volt_ff      <= 16'h0000;
      fbase_ff     <= `FLJ_RST_BASEF;
      inflect_ff   <= 16'h0000;
      boost_out_ff <= 16'h0000;
    end else begin
      volt_ff  <= nxt_volt;
      fbase_ff <= fbase;
      inflect_ff <= (curve_ff == `FLJ_CURVE_SA) ? fbase : 16'h0000;
      if ((patt_ff == FLJVF_HOIST_FWD && REVERSE_IN) ||
          (patt_ff == FLJVF_HOIST_REV && !REVERSE_IN)) begin
        boost_out_ff <= 16'h0000;
      end else if (second_set_ff && boost2_ff != `FLJ_OFF) begin
        boost_out_ff <= boost2_ff;
      end else begin
        boost_out_ff <= boost_ff;
      end
    end
  end

  // Locked write flag, one cycle.
  always_ff @(posedge CORE_CLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      reject_ff <= 1'b0;
    end else begin
      reject_ff <= PARAM_WR_IN && !wr_ok;
    end
  end

  // Output wiring from registers.
  assign WR_REJECT_OUT  = reject_ff;
  assign SECOND_SET_OUT = second_set_ff;
  assign TARGET_OUT     = target_ff;
  assign FREQ_OUT       = freq_ff;
  assign VOLT_OUT       = volt_ff;
  assign BOOST_OUT      = boost_out_ff;
  assign BASE_FREQ_OUT  = fbase_ff;
  assign INFLECT_OUT    = inflect_ff;

  // Checks on the block's own behaviour.
  default clocking cb @(posedge CORE_CLK_IN); endclocking
  default disable iff (RST_IN);

  sequence s_locked_wr;
    PARAM_WR_IN && group_ff != 16'h0000 && PARAM_ID_IN != `FLJ_ID_GROUP;
  endsequence
  sequence s_stall_cut;
    STALL_IN && STALL_FREQ_IN < freq_ff;
  endsequence
  property p_max_clamp;
    1 |=> target_ff <= $past(maxf_ff) || $past(zone_hit) != 3'b000;
  endproperty
  a_max_clamp: assert property (p_max_clamp)
    else $error("target above maximum");
  property p_min_clamp;
    START_IN && !JOG_IN && zone_hit == 3'b000 && minf_ff <= maxf_ff &&
    minf_ff >= startf_ff && FREQ_CMD_IN < minf_ff
    |=> target_ff == $past(minf_ff);
  endproperty
  a_min_clamp: assert property (p_min_clamp)
    else $error("minimum clamp missed");
  property p_jog;
    JOG_IN && zone_hit == 3'b000 && jogf_ff <= maxf_ff
    |=> target_ff == $past(jogf_ff);
  endproperty
  a_jog: assert property (p_jog)
    else $error("jog not taken");
  property p_stall;
    s_stall_cut |=> freq_ff == $past(STALL_FREQ_IN);
  endproperty
  a_stall: assert property (p_stall)
    else $error("stall reduction not followed");
  property p_ramp_step;
    !STALL_IN |=> freq_ff - $past(freq_ff) <= `FLJ_STEP ||
                  $past(freq_ff) - freq_ff <= `FLJ_STEP;
  endproperty
  a_ramp_step: assert property (p_ramp_step)
    else $error("ramp skipped frequencies");
  property p_second_base;
    second_set_ff && sbasef_ff != `FLJ_OFF && !FLUX_MODE_IN
    |=> BASE_FREQ_OUT == $past(sbasef_ff);
  endproperty
  a_second_base: assert property (p_second_base)
    else $error("second base frequency unused");
  property p_volt_limit;
    !FLUX_MODE_IN && basev_ff < SUPPLY_VOLT_IN && basev_ff != `FLJ_V95
    |=> VOLT_OUT <= $past(basev_ff);
  endproperty
  a_volt_limit: assert property (p_volt_limit)
    else $error("voltage above base voltage");
  property p_rev_boost;
    (patt_ff == FLJVF_HOIST_FWD && REVERSE_IN) ||
    (patt_ff == FLJVF_HOIST_REV && !REVERSE_IN) |=> BOOST_OUT == 16'h0000;
  endproperty
  a_rev_boost: assert property (p_rev_boost)
    else $error("hoist boost not zero in its idle direction");
  property p_locked;
    s_locked_wr |=> WR_REJECT_OUT ##1 !WR_REJECT_OUT || $past(PARAM_WR_IN);
  endproperty
  a_locked: assert property (p_locked)
    else $error("locked write not flagged");
endmodule

// ===== fljvf_src.sv
// Purpose: Frequency command source standing in front of the block.
// Assumes: The source changes its level away from the sampling edge.
// Notes:   Plain level source; it never glitches between settings.
`timescale 1ns/1ps
module fljvf_src (
  // Clock.
  input  wire logic                  clk_in,
  // Level requested by the bench.
  input  wire fljvf_pkg::fljvf_val_t set_in,
  // Command handed to the block.
  output fljvf_pkg::fljvf_val_t      freq_cmd_out
);
  import fljvf_pkg::*;
  // Update on the falling edge, half a cycle clear of sampling.
  always @(negedge clk_in) begin
    freq_cmd_out <= set_in;
  end
endmodule

// ===== testbench.sv
// Purpose: Self-checking bench for the clamp, jump and V/F block.
// Assumes: Units of 0.1 Hz and 1 V; supply held at 400 V.
// Notes:   Ramp waits are bounded; a cycle ceiling ends a hang.
`timescale 1ns/1ps
`include "fljvf_defs.svh"
module testbench;
  import fljvf_pkg::*;
  logic        clk     = 1'b0;
  logic        rst     = 1'b1;
  logic        wr      = 1'b0;
  logic [7:0]  id      = 8'h00;
  fljvf_val_t  data    = 16'h0000;
  logic        start   = 1'b0;
  logic        rev     = 1'b0;
  logic        jog     = 1'b0;
  logic        stall   = 1'b0;
  logic        flux    = 1'b0;
  fljvf_val_t  cmd_set = 16'h0000;
  fljvf_val_t  stall_f = 16'h0000;
  fljvf_val_t  supply  = 16'h0190;
  logic [6:0]  term    = 7'h00;
  logic [34:0] tfunc   = 35'h0;
  logic        reject;
  logic        second;
  fljvf_val_t  cmd;
  fljvf_val_t  target;
  fljvf_val_t  freq;
  fljvf_val_t  volt;
  fljvf_val_t  boost;
  fljvf_val_t  basef;
  fljvf_val_t  inflect;
  int          errors    = 0;
  int          cmp_count = 0;
  int          cycles    = 0;

  fljvf_top i_fljvf_top (.CORE_CLK_IN(clk), .RST_IN(rst), .PARAM_WR_IN(wr),
    .PARAM_ID_IN(id), .PARAM_DATA_IN(data), .START_IN(start),
    .REVERSE_IN(rev), .JOG_IN(jog), .FREQ_CMD_IN(cmd), .STALL_IN(stall),
    .STALL_FREQ_IN(stall_f), .FLUX_MODE_IN(flux), .SUPPLY_VOLT_IN(supply),
    .TERM_IN(term), .TERM_FUNC_IN(tfunc), .WR_REJECT_OUT(reject),
    .SECOND_SET_OUT(second), .TARGET_OUT(target), .FREQ_OUT(freq),
    .VOLT_OUT(volt), .BOOST_OUT(boost), .BASE_FREQ_OUT(basef),
    .INFLECT_OUT(inflect));
  fljvf_src i_fljvf_src (.clk_in(clk), .set_in(cmd_set), .freq_cmd_out(cmd));

  // Clock of 10 ns period.
  always #5 clk = ~clk;

  // Cycle ceiling well above the roughly 16000 cycles the run needs.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input fljvf_val_t got, input fljvf_val_t exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One-cycle write pulse, launched and dropped on falling edges.
  task automatic wr_set(input logic [7:0] i, input fljvf_val_t d);
    @(negedge clk);
    wr = 1'b1;
    id = i;
    data = d;
    @(negedge clk);
    wr = 1'b0;
  endtask

  // Covers source delay plus the registered outputs.
  task automatic settle();
    repeat (4) @(negedge clk);
  endtask

  task automatic wait_freq(input fljvf_val_t v);
    int n;
    n = 0;
    while (freq !== v && n < 20000) begin
      @(negedge clk);
      n++;
    end
    chk(freq, v);
  endtask

  // Reset values seen right at release.
  task automatic t_reset();
    chk(basef, 16'h01F4);
    chk(target, 16'h0000);
  endtask

  task automatic t_min_jog();
    start = 1'b1;
    wr_set(`FLJ_ID_MINF, 16'h0064);
    cmd_set = 16'h0032;
    settle();
    chk(target, 16'h0064);
    jog = 1'b1;
    settle();
    chk(target, 16'h0032);
    jog = 1'b0;
  endtask

  task automatic t_max_jump();
    logic [7:0] j;
    wr_set(`FLJ_ID_MAXF, 16'h0320);
    cmd_set = 16'h03E8;
    settle();
    chk(target, 16'h0320);
    cmd_set = 16'h0226;
    for (int z = 0; z < 3; z++) begin
      j = `FLJ_ID_JUMP0 + 8'(2 * z);
      wr_set(j, 16'h0258);
      wr_set(j + 8'h01, 16'h01F4);
      settle();
      chk(target, 16'h0258);
      wr_set(j + 8'h01, `FLJ_OFF);
      settle();
      chk(target, 16'h0226);
      wr_set(j, `FLJ_OFF);
    end
    wr_set(`FLJ_ID_JUMP0, 16'h012C);
    wr_set(`FLJ_ID_JUMP0 + 8'h01, 16'h015E);
    cmd_set = 16'h0140;
    settle();
    chk(target, 16'h012C);
  endtask

  task automatic t_ramp_stall();
    wr_set(`FLJ_ID_JUMP0, 16'h001E);
    wr_set(`FLJ_ID_JUMP0 + 8'h01, 16'h003C);
    cmd_set = 16'h0000;
    settle();
    chk(target, 16'h0064);
    wait_freq(16'h002D);
    wait_freq(16'h0064);
    stall_f = 16'h0028;
    stall = 1'b1;
    @(negedge clk);
    chk(freq, 16'h0028);
    stall = 1'b0;
    wait_freq(16'h0064);
  endtask

  task automatic t_volt();
    wr_set(`FLJ_ID_BASEF, 16'h00C8);
    settle();
    chk(volt, 16'h00BE);
    chk(inflect, 16'h0000);
    wr_set(`FLJ_ID_BASEV, `FLJ_OFF);
    settle();
    chk(volt, 16'h00C8);
    wr_set(`FLJ_ID_BASEV, 16'h012C);
    settle();
    chk(volt, 16'h0096);
    wr_set(`FLJ_ID_PATT, 16'h0001);
    settle();
    chk(volt, 16'h004B);
  endtask

  task automatic t_second();
    term[2] = 1'b1;
    settle();
    chk({15'h0000, second}, 16'h0000);
    tfunc[14:10] = `FLJ_SEL_SET2;
    settle();
    chk({15'h0000, second}, 16'h0001);
    chk(basef, 16'h00C8);
    wr_set(`FLJ_ID_SBASEF, 16'h0064);
    wr_set(`FLJ_ID_CURVE, `FLJ_CURVE_SA);
    settle();
    chk(basef, 16'h0064);
    chk(volt, 16'h012C);
    chk(inflect, 16'h0064);
    term[2] = 1'b0;
    settle();
    chk(basef, 16'h00C8);
    term[2] = 1'b1;
  endtask

  task automatic t_boost();
    for (int p = 2; p < 4; p++) begin
      for (int r = 0; r < 2; r++) begin
        wr_set(`FLJ_ID_PATT, 16'(p));
        rev = r[0];
        settle();
        chk(boost, ((p == 2) == (r == 1)) ? 16'h0000 : 16'h0032);
      end
    end
    wr_set(`FLJ_ID_PATT, 16'h0002);
    wr_set(`FLJ_ID_BOOST2, 16'h001E);
    rev = 1'b0;
    settle();
    chk(boost, 16'h001E);
    flux = 1'b1;
    settle();
    chk(volt, 16'h0028);
    flux = 1'b0;
  endtask

  task automatic t_lock();
    fljvf_val_t seen;
    seen = 16'h0000;
    wr_set(`FLJ_ID_GROUP, 16'h0001);
    @(negedge clk);
    wr = 1'b1;
    id = `FLJ_ID_MINF;
    data = 16'h00C8;
    for (int i = 0; i < 3; i++) begin
      @(negedge clk);
      wr = 1'b0;
      if (reject === 1'b1) begin
        seen = seen + 16'h0001;
      end
    end
    chk(seen, 16'h0001);
    cmd_set = 16'h0000;
    settle();
    chk(target, 16'h0064);
    wr_set(`FLJ_ID_GROUP, 16'h0000);
  endtask

  // Reset for two cycles, then the scenarios in order.
  initial begin
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_min_jog();
    t_max_jump();
    t_ramp_stall();
    t_volt();
    t_second();
    t_boost();
    t_lock();
    end_sim();
  end
endmodule
